//--- rtl/bfs_pg_deglitch.sv
// power-good window deglitch with asymmetric persistence counts
`timescale 1ns/1ps
module bfs_pg_deglitch #(
    parameter int RISE_CYC = bfs_pkg::PG_RISE_CYCLES,
    parameter int FALL_CYC = bfs_pkg::PG_FALL_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic cyc_tick_i,
    input wire logic in_window_i,
    output logic pg_o
);
    localparam int CW = $clog2(RISE_CYC + 1);

    typedef struct packed {
        logic pg;
        logic [CW-1:0] cnt;
    } bfs_pg_state_t;

    bfs_pg_state_t st_reg;
    bfs_pg_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (in_window_i == st_reg.pg) begin
            st_next.cnt = '0;
        end else if (cyc_tick_i) begin
            st_next.cnt = st_reg.cnt + CW'(1);
            if (!st_reg.pg && st_reg.cnt == CW'(RISE_CYC - 1)) begin
                st_next.pg = 1'b1;
                st_next.cnt = '0;
            end
            if (st_reg.pg && st_reg.cnt == CW'(FALL_CYC - 1)) begin
                st_next.pg = 1'b0;
                st_next.cnt = '0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pg_o = st_reg.pg;
endmodule

//--- rtl/bfs_pkg.sv
// constants and carrier types for the buck fault and power-good sequencer
package bfs_pkg;
    // clock rate in MHz, 8 ns period
    localparam int CLK_MHZ = 125;
    localparam int CLK_PERIOD_NS = 8;
    // deglitch cycle counts
    localparam int PG_RISE_CYCLES = 1024;
    localparam int PG_FALL_CYCLES = 16;
    // overcurrent events before hiccup
    localparam int OC_HICCUP_COUNT = 10;
    // hiccup off time in clock cycles
    localparam int HICCUP_CYCLES = 4096;
    // switch timing in ns
    localparam int MIN_ON_NS = 125;
    localparam int MIN_OFF_NS = 200;
    // least times round up to whole cycles
    localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // maximum duty in percent
    localparam int MAX_DUTY_PCT = 90;
    // default switching period in clocks (1 MHz)
    localparam int SW_PERIOD_CYC = 125;
    // foldback divide codes
    localparam logic [1:0] DIV_FULL = 2'h0;
    localparam logic [1:0] DIV_HALF = 2'h1;
    localparam logic [1:0] DIV_QUARTER = 2'h3;

    // comparator flags from the analog side
    typedef struct packed {
        logic fb_over_upper;   // above upper pg window threshold
        logic fb_under_lower;  // below lower pg window threshold
        logic fb_ge_0p4;       // feedback at or above 0.4 V
        logic fb_ge_0p2;       // feedback at or above 0.2 V
        logic fb_ovp_0p7;      // feedback at or above 0.7 V
        logic fb_ge_0p63;      // feedback at or above 0.63 V
        logic peak_limit;      // peak current limit tripped
        logic sink_limit;      // sink current limit tripped
        logic uv_below_3p8;    // supply below 3.8 V
        logic uv_above_4p3;    // supply above 4.3 V
        logic ot_above_150;    // die above 150 C
        logic ot_below_125;    // die below 125 C
        logic pwm_trip;        // peak current loop comparator
        logic ss_done;         // soft start ramp finished
    } bfs_flags_t;

    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } bfs_gate_t;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_SOFT = 3'b001,
        ST_RUN = 3'b010,
        ST_HICCUP = 3'b011,
        ST_OVP = 3'b100,
        ST_THERMAL = 3'b101
    } bfs_state_t;
endpackage

//--- rtl/bfs_sequencer.sv
// buck switch sequencer: pwm, foldback, hiccup, ovp, uvlo, thermal and power good
`timescale 1ns/1ps
// Overview of operation
// - power good released only inside window
// - overvoltage holds power good low
// - undervoltage holds power good low
// - 1024 cycles before power good rises
// - 16 cycles before power good falls
// - soft start foldback full, half, quarter
// - peak limit: low side on, count
// - hiccup at ten faults or low feedback
// - hiccup: both off 4096 cycles
// - restart resumes or hiccups again
// - sink limit: both off until cycle
// - overvoltage off until 0.63 V
// - supply lockout 3.8 V, start 4.3 V
// - thermal off above 150, back below 125
// - minimum on time 125 ns
// - minimum off 200 ns, duty 90 percent
// - cycle start high side, trip low side
module bfs_sequencer #(
    parameter int PERIOD_CYC = bfs_pkg::SW_PERIOD_CYC,
    parameter int HICCUP_CYC = bfs_pkg::HICCUP_CYCLES,
    parameter int OC_LIMIT = bfs_pkg::OC_HICCUP_COUNT,
    parameter int PG_RISE = bfs_pkg::PG_RISE_CYCLES,
    parameter int PG_FALL = bfs_pkg::PG_FALL_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input bfs_pkg::bfs_flags_t flags_i,
    output bfs_pkg::bfs_gate_t gate_o,
    output logic power_good_out_o,
    output logic power_good_out_oe_o,
    output logic hiccup_o,
    output logic [1:0] fold_div_o
);
    localparam int PW = $clog2(PERIOD_CYC * 4 + 1);
    localparam int HW = $clog2(HICCUP_CYC + 1);
    localparam int OW = $clog2(OC_LIMIT + 1);
    // duty ceiling from the shorter of min off and 90 percent
    localparam int DUTY_CYC = (PERIOD_CYC * bfs_pkg::MAX_DUTY_PCT) / 100;
    localparam int OFF_CAP = PERIOD_CYC - bfs_pkg::MIN_OFF_CYC;
    localparam int MAX_ON = (DUTY_CYC < OFF_CAP) ? DUTY_CYC : OFF_CAP;

    typedef struct packed {
        bfs_pkg::bfs_state_t mode;
        logic [PW-1:0] phase;
        logic [1:0] div;
        logic hs;
        logic ls;
        logic tripped;
        logic sink_block;
        logic [OW-1:0] oc_cnt;
        logic [HW-1:0] hic_cnt;
        logic ss_seen;
    } bfs_seq_state_t;

    bfs_seq_state_t st_reg;
    bfs_seq_state_t st_next;
    logic cycle_end;
    logic [PW-1:0] period_len;
    logic pg_raw;
    logic in_window;
    logic switching;

    // scale the period by the foldback divider
    function automatic logic [PW-1:0] scaled_period(input logic [1:0] d);
        logic [PW-1:0] p;
        p = PW'(PERIOD_CYC);
        unique case (d)
            bfs_pkg::DIV_HALF: scaled_period = PW'(p << 1);
            bfs_pkg::DIV_QUARTER: scaled_period = PW'(p << 2);
            default: scaled_period = p;
        endcase
    endfunction

    assign period_len = scaled_period(st_reg.div);
    assign cycle_end = (st_reg.phase == period_len - PW'(1));
    assign switching = (st_reg.mode == bfs_pkg::ST_SOFT) || (st_reg.mode == bfs_pkg::ST_RUN);

    always_comb begin
        st_next = st_reg;
        st_next.phase = cycle_end ? '0 : st_reg.phase + PW'(1);
        unique case (st_reg.mode)
            bfs_pkg::ST_OFF: begin
                st_next.hs = 1'b0;
                st_next.ls = 1'b0;
                st_next.oc_cnt = '0;
                // start when supply above 4.3 V
                if (flags_i.uv_above_4p3 && !flags_i.ot_above_150) begin
                    st_next.mode = bfs_pkg::ST_SOFT;
                    st_next.ss_seen = 1'b0;
                    st_next.phase = '0;
                end
            end
            bfs_pkg::ST_HICCUP: begin
                st_next.hs = 1'b0;
                st_next.ls = 1'b0;
                st_next.hic_cnt = st_reg.hic_cnt + HW'(1);
                // both off for the hiccup time
                if (st_reg.hic_cnt == HW'(HICCUP_CYC - 1)) begin
                    st_next.mode = bfs_pkg::ST_SOFT;
                    st_next.oc_cnt = '0;
                    st_next.ss_seen = 1'b0;
                    st_next.phase = '0;
                end
            end
            bfs_pkg::ST_OVP: begin
                st_next.hs = 1'b0;
                st_next.ls = 1'b0;
                // resume once feedback under 0.63 V
                if (!flags_i.fb_ge_0p63) begin
                    st_next.mode = bfs_pkg::ST_RUN;
                    st_next.phase = '0;
                end
            end
            bfs_pkg::ST_THERMAL: begin
                st_next.hs = 1'b0;
                st_next.ls = 1'b0;
                if (flags_i.ot_below_125) begin
                    st_next.mode = bfs_pkg::ST_SOFT;
                    st_next.ss_seen = 1'b0;
                    st_next.phase = '0;
                end
            end
            default: begin
                // soft start and run share the pwm engine
                if (flags_i.ss_done) begin
                    st_next.ss_seen = 1'b1;
                    st_next.mode = bfs_pkg::ST_RUN;
                end
                if (cycle_end) begin
                    if (st_reg.ss_seen || flags_i.fb_ge_0p4) begin
                        st_next.div = bfs_pkg::DIV_FULL;
                    end else if (flags_i.fb_ge_0p2) begin
                        st_next.div = bfs_pkg::DIV_HALF;
                    end else begin
                        st_next.div = bfs_pkg::DIV_QUARTER;
                    end
                    // high side on at cycle start
                    st_next.hs = 1'b1;
                    st_next.ls = 1'b0;
                    st_next.tripped = 1'b0;
                    st_next.sink_block = 1'b0;
                end else if (st_reg.sink_block) begin
                    st_next.hs = 1'b0;
                    st_next.ls = 1'b0;
                end else if (flags_i.sink_limit && st_reg.ls) begin
                    st_next.hs = 1'b0;
                    st_next.ls = 1'b0;
                    st_next.sink_block = 1'b1;
                end else if (st_reg.hs) begin
                    // peak limit ends high side, counts
                    if (flags_i.peak_limit) begin
                        st_next.hs = 1'b0;
                        st_next.ls = 1'b1;
                        st_next.tripped = 1'b1;
                        st_next.oc_cnt = st_reg.oc_cnt + OW'(1);
                    end else if (st_reg.phase >= PW'(MAX_ON - 1)) begin
                        st_next.hs = 1'b0;
                        st_next.ls = 1'b1;
                    // pwm trip honoured after min on
                    end else if (flags_i.pwm_trip && st_reg.phase >= PW'(bfs_pkg::MIN_ON_CYC - 1)) begin
                        st_next.hs = 1'b0;
                        st_next.ls = 1'b1;
                    end
                end
                // hiccup on count or low feedback
                if (st_next.oc_cnt >= OW'(OC_LIMIT) || (st_reg.ss_seen && !flags_i.fb_ge_0p4)) begin
                    st_next.mode = bfs_pkg::ST_HICCUP;
                    st_next.oc_cnt = '0;
                    st_next.hic_cnt = '0;
                    st_next.hs = 1'b0;
                    st_next.ls = 1'b0;
                end
                if (flags_i.fb_ovp_0p7) begin
                    st_next.mode = bfs_pkg::ST_OVP;
                    st_next.hs = 1'b0;
                    st_next.ls = 1'b0;
                end
            end
        endcase
        // thermal trip wins over all but lockout
        if (flags_i.ot_above_150 && st_reg.mode != bfs_pkg::ST_OFF) begin
            st_next.mode = bfs_pkg::ST_THERMAL;
            st_next.hs = 1'b0;
            st_next.ls = 1'b0;
        end
        // lockout below 3.8 V overrides everything
        if (flags_i.uv_below_3p8) begin
            st_next.mode = bfs_pkg::ST_OFF;
            st_next.hs = 1'b0;
            st_next.ls = 1'b0;
            st_next.div = bfs_pkg::DIV_QUARTER;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_reg <= '0;
            st_reg.mode <= bfs_pkg::ST_OFF;
            st_reg.div <= bfs_pkg::DIV_QUARTER;
        end else begin
            st_reg <= st_next;
        end
    end

    // window is neither over nor under
    assign in_window = !flags_i.fb_over_upper && !flags_i.fb_under_lower && switching;

    // deglitch counts switching cycles, one tick per period as scaled by the foldback divider
    bfs_pg_deglitch #(
        .RISE_CYC(PG_RISE),
        .FALL_CYC(PG_FALL)
    ) u_pg (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cyc_tick_i(st_reg.phase == '0),
        .in_window_i(in_window),
        .pg_o(pg_raw)
    );

    // open drain: output stays low, enable pulls the pin down
    assign power_good_out_o = 1'b0;
    assign power_good_out_oe_o = !pg_raw;
    assign gate_o.hs_on = st_reg.hs && switching;
    assign gate_o.ls_on = st_reg.ls && switching;
    assign hiccup_o = (st_reg.mode == bfs_pkg::ST_HICCUP);
    assign fold_div_o = st_reg.div;
endmodule

//--- tb/bfs_plant.sv
// partner model: comparators of the power stage and the power-good pull-up
`timescale 1ns/1ps
module bfs_plant #(
    parameter int PG_UP_MV = 660,
    parameter int PG_LO_MV = 540
) (
    input int fb_mv_i,
    input int vin_mv_i,
    input int tmp_c_i,
    input wire logic peak_i,
    input wire logic sink_i,
    input wire logic trip_i,
    input wire logic ssd_i,
    input wire logic pg_data_i,
    input wire logic pg_oe_i,
    output bfs_pkg::bfs_flags_t flags_o,
    output logic pg_pin_o
);
    // window edges are plain defaults; the lockout and thermal gaps give hysteresis
    assign flags_o = {fb_mv_i > PG_UP_MV, fb_mv_i < PG_LO_MV, fb_mv_i >= 400, fb_mv_i >= 200,
        fb_mv_i >= 700, fb_mv_i >= 630, peak_i, sink_i, vin_mv_i < 3800, vin_mv_i > 4300,
        tmp_c_i > 150, tmp_c_i < 125, trip_i, ssd_i};
    // pin floats up through the external resistor when released
    assign pg_pin_o = pg_oe_i ? pg_data_i : 1'b1;
endmodule

//--- tb/bfs_sequencer_tb.sv
// self-checking bench for the buck sequencer
`timescale 1ns/1ps
module bfs_sequencer_tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    bfs_pkg::bfs_flags_t flags;
    bfs_pkg::bfs_gate_t gate;
    logic pg_data, pg_oe, hic, pg_pin;
    logic [1:0] fold;
    logic pk = 1'b0, snk = 1'b0, trip = 1'b0, ssd = 1'b0;
    int fb_mv = 0, vin_mv = 0, tmp_c = 25, fails = 0, compares = 0, w;
    bfs_sequencer #(.PERIOD_CYC(125), .HICCUP_CYC(64), .OC_LIMIT(10), .PG_RISE(8), .PG_FALL(4)) DUT (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .flags_i(flags), .gate_o(gate),
        .power_good_out_o(pg_data), .power_good_out_oe_o(pg_oe), .hiccup_o(hic), .fold_div_o(fold));
    bfs_plant u_plant (.fb_mv_i(fb_mv), .vin_mv_i(vin_mv), .tmp_c_i(tmp_c), .peak_i(pk), .sink_i(snk),
        .trip_i(trip), .ssd_i(ssd), .pg_data_i(pg_data), .pg_oe_i(pg_oe), .flags_o(flags), .pg_pin_o(pg_pin));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bounded wait for the next high side pulse
    task automatic wait_hs();
        int n;
        n = 0;
        while (gate.hs_on !== 1'b1 && n < 600) begin
            n++;
            cyc(1);
        end
        chk(n < 600, 1);
    endtask
    task automatic hs_width(output int n);
        wait_hs();
        n = 0;
        while (gate.hs_on === 1'b1 && n < 600) begin
            n++;
            cyc(1);
        end
    endtask
    task automatic pulse_peak();
        wait_hs();
        pk = 1'b1;
        cyc(1);
        pk = 1'b0;
    endtask
    // fault, then a level that must not yet release, then recovery
    task automatic t_lock(ref int v, input int bad, input int mid, input int good);
        v = bad;
        cyc(2);
        chk(gate, 2'h0);
        v = mid;
        cyc(300);
        chk(gate, 2'h0);
        v = good;
        wait_hs();
        $display("test lock end");
    endtask
    task automatic t_fold();
        int lv[3] = '{100, 300, 450};
        logic [1:0] ex[3] = '{bfs_pkg::DIV_QUARTER, bfs_pkg::DIV_HALF, bfs_pkg::DIV_FULL};
        vin_mv = 5000;
        for (int i = 0; i < 3; i++) begin
            fb_mv = lv[i];
            cyc(520);
            chk(fold, ex[i]);
        end
        chk(pg_pin, 0);
        $display("test fold end");
    endtask
    task automatic t_pg();
        fb_mv = 600;
        cyc(625);
        chk(pg_pin, 0);
        cyc(625);
        chk(pg_pin, 1);
        // short excursions must keep restarting the fall count
        repeat (2) begin
            fb_mv = 680;
            cyc(250);
            fb_mv = 600;
            cyc(125);
        end
        chk(pg_pin, 1);
        fb_mv = 680;
        cyc(750);
        chk(pg_pin, 0);
        fb_mv = 500;
        cyc(250);
        chk(pg_pin, 0);
        fb_mv = 600;
        cyc(1250);
        chk(pg_pin, 1);
        $display("test pg end");
    endtask
    task automatic t_hiccup();
        repeat (9) begin
            pulse_peak();
            chk(gate, 2'h1);
            chk(hic, 0);
        end
        pulse_peak();
        cyc(2);
        chk(hic, 1);
        chk(gate, 2'h0);
        cyc(64);
        chk(hic, 0);
        wait_hs();
        repeat (9) pulse_peak();
        cyc(2);
        chk(hic, 0);
        // fault still present after the restart: hiccup again
        pulse_peak();
        cyc(2);
        chk(hic, 1);
        cyc(70);
        chk(hic, 0);
        $display("test hiccup end");
    endtask
    task automatic t_width();
        trip = 1'b1;
        hs_width(w);
        chk(w >= bfs_pkg::MIN_ON_CYC && w <= bfs_pkg::MIN_ON_CYC + 1, 1);
        cyc(5);
        chk(gate, 2'h1);
        snk = 1'b1;
        cyc(1);
        snk = 1'b0;
        chk(gate, 2'h0);
        trip = 1'b0;
        hs_width(w);
        chk(w >= 95 && w <= 100, 1);
        $display("test width end");
    endtask
    task automatic t_lowfb();
        ssd = 1'b1;
        cyc(10);
        fb_mv = 300;
        cyc(3);
        chk(hic, 1);
        fb_mv = 600;
        cyc(70);
        chk(hic, 0);
        $display("test lowfb end");
    endtask
    initial begin
        cyc(6);
        reset_i = 1'b0;
        t_fold();
        t_pg();
        t_hiccup();
        t_lock(vin_mv, 3700, 4000, 4500);
        t_lock(tmp_c, 160, 140, 120);
        t_lock(fb_mv, 720, 650, 600);
        t_width();
        t_lowfb();
        end_sim();
    end
    // hang guard, several times the expected run
    initial begin
        cyc(40000);
        fails++;
        end_sim();
    end
endmodule

//--- tb/bfs_sva.sv
// port assertions for the buck sequencer
`timescale 1ns/1ps
module bfs_sva #(
    parameter int PERIOD_CYC = 125,
    parameter int HICCUP_CYC = 4096
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input bfs_pkg::bfs_flags_t flags_i,
    input bfs_pkg::bfs_gate_t gate_o,
    input wire logic power_good_out_o,
    input wire logic power_good_out_oe_o,
    input wire logic hiccup_o,
    input wire logic [1:0] fold_div_o
);
    localparam int DUTY_ON = PERIOD_CYC * bfs_pkg::MAX_DUTY_PCT / 100;
    localparam int OFF_ON = PERIOD_CYC - bfs_pkg::MIN_OFF_CYC;
    localparam int MAX_ON = (DUTY_ON < OFF_ON) ? DUTY_ON : OFF_ON;
    logic [15:0] hic_reg;
    logic [15:0] on_reg;
    logic off_w;
    logic win_w;
    assign off_w = !gate_o.hs_on && !gate_o.ls_on;
    assign win_w = !flags_i.fb_over_upper && !flags_i.fb_under_lower;
    // run lengths, so long counts need no deep repetition
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hic_reg <= 16'h0000;
            on_reg <= 16'h0000;
        end else begin
            hic_reg <= hiccup_o ? hic_reg + 16'h0001 : 16'h0000;
            on_reg <= gate_o.hs_on ? on_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    AST_PG_DATA: assert property (power_good_out_o == 1'b0)
        else $error("power good data not low");
    AST_PG_RISE: assert property ($fell(power_good_out_oe_o) |-> $past(win_w) && $past(win_w, 300))
        else $error("power good released without settled window");
    // high side must already be on: a trip at the cycle boundary lets the new cycle start
    AST_PEAK: assert property (flags_i.peak_limit && gate_o.hs_on && !hiccup_o |=> !gate_o.hs_on)
        else $error("high side on after peak limit");
    AST_HIC_OFF: assert property (hiccup_o |-> off_w)
        else $error("switch on during hiccup");
    // lockout or thermal may legally cut a hiccup short
    AST_HIC_LEN: assert property ($fell(hiccup_o) && !$past(flags_i.uv_below_3p8) && !$past(flags_i.ot_above_150)
        |-> hic_reg >= HICCUP_CYC && hic_reg <= HICCUP_CYC + 1)
        else $error("hiccup length wrong");
    AST_SINK: assert property (flags_i.sink_limit |=> !gate_o.ls_on)
        else $error("low side on after sink limit");
    AST_OVP: assert property (flags_i.fb_ovp_0p7 |=> off_w)
        else $error("switch on in overvoltage");
    AST_UV: assert property (flags_i.uv_below_3p8 |=> off_w)
        else $error("switch on below lockout");
    AST_OT: assert property (flags_i.ot_above_150 |=> off_w)
        else $error("switch on when hot");
    AST_MAX_ON: assert property (on_reg <= MAX_ON)
        else $error("high side on too long");
    AST_FOLD: assert property (fold_div_o != 2'h2)
        else $error("bad foldback code");
endmodule
bind bfs_sequencer bfs_sva #(.PERIOD_CYC(PERIOD_CYC), .HICCUP_CYC(HICCUP_CYC)) u_sva (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .flags_i(flags_i), .gate_o(gate_o),
    .power_good_out_o(power_good_out_o), .power_good_out_oe_o(power_good_out_oe_o),
    .hiccup_o(hiccup_o), .fold_div_o(fold_div_o));
